// ===== rtl/acc_pkg.sv
`default_nettype none
package acc_pkg;

	// ------------------------------------------------------------
	// Register map (byte offsets)
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_MASKED_IRQ_STATUS = 8'h00;
	localparam logic [7:0] OFF_RAW_IRQ_STATUS = 8'h04;
	localparam logic [7:0] OFF_IRQ_MASK_REG = 8'h08;
	localparam logic [7:0] OFF_LADDER_REFERENCE_CONTROL = 8'h10;
	localparam logic [7:0] OFF_CHANNEL_STATUS_BASE = 8'h20;
	localparam logic [7:0] OFF_CHANNEL_CONTROL_BASE = 8'h24;
	localparam logic [7:0] OFF_CHANNEL_STRIDE = 8'h20;

	localparam int NUM_CHANNELS = 3;
	localparam int LEVEL_W = 10;

	// ------------------------------------------------------------
	// Channel control fields
	// ------------------------------------------------------------
	localparam int CTL_W = 12;
	localparam int CTL_INVERT_BIT = 1;
	localparam int CTL_INT_SENSE_LSB = 2;
	localparam int CTL_INT_LEVEL_BIT = 4;
	localparam int CTL_TRIG_SENSE_LSB = 5;
	localparam int CTL_TRIG_LEVEL_BIT = 7;
	localparam int CTL_PLUS_SOURCE_LSB = 9;
	localparam int CTL_PIN_ENABLE_BIT = 11;
	localparam logic [CTL_W-1:0] CTL_RESET = 12'h000;

	// Status register: current result
	localparam int STAT_RESULT_BIT = 1;

	// ------------------------------------------------------------
	// Ladder reference fields
	// ------------------------------------------------------------
	localparam int REF_W = 10;
	localparam int REF_TAP_LSB = 0;
	localparam int REF_SPAN_BIT = 8;
	localparam int REF_EN_BIT = 9;
	localparam logic [REF_W-1:0] REF_RESET = 10'h000;
	localparam logic [4:0] LADDER_OFFSET_LOW_SPAN = 5'h08;
	localparam logic [14:0] LADDER_TOTAL_LOW_SPAN = 15'h001f;
	localparam logic [14:0] LADDER_TOTAL_HIGH_SPAN = 15'h0017;

	localparam logic [2:0] IRQ_RESET = 3'h0;

	// ------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------
	localparam logic [1:0] SRC_OWN_PIN = 2'h0;
	localparam logic [1:0] SRC_SHARED_PLUS = 2'h1;
	localparam logic [1:0] SRC_LADDER = 2'h2;

	localparam logic [1:0] SENSE_LEVEL = 2'h0;
	localparam logic [1:0] SENSE_FALL = 2'h1;
	localparam logic [1:0] SENSE_RISE = 2'h2;
	localparam logic [1:0] SENSE_BOTH = 2'h3;

	function automatic logic sense_hit(input logic [1:0] mode, input logic lvl, input logic val,
		input logic rise, input logic fall);
		logic hit;
		hit = 1'b0;
		case (mode)
			SENSE_LEVEL: hit = (val == lvl);
			SENSE_FALL: hit = fall;
			SENSE_RISE: hit = rise;
			SENSE_BOTH: hit = rise | fall;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

endpackage
`default_nettype wire

// ===== rtl/acc_ch_if.sv
`timescale 1ns/1ps
`default_nettype none
interface acc_ch_if;
	logic raw_cmp;
	logic invert;
	logic [1:0] int_sense;
	logic int_level;
	logic [1:0] trig_sense;
	logic trig_level;
	logic result;
	logic int_evt;
	logic trig;

	modport ctrl (
		output raw_cmp, invert, int_sense, int_level, trig_sense, trig_level,
		input result, int_evt, trig
	);
	modport chan (
		input raw_cmp, invert, int_sense, int_level, trig_sense, trig_level,
		output result, int_evt, trig
	);
endinterface
`default_nettype wire

// ===== rtl/acc_channel.sv
`timescale 1ns/1ps
`default_nettype none
module acc_channel (
	input wire logic i_clk,
	input wire logic i_rst,
	acc_ch_if.chan ch
);
	import acc_pkg::*;

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic prev;
		logic trig;
	} acc_chan_s;

	acc_chan_s st_q;
	acc_chan_s st_d;
	logic val;
	logic pval;
	logic rise;
	logic fall;

	// ------------------------------------------------------------
	// Synchroniser, edge detect and condition logic
	// ------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.sync1 = ch.raw_cmp;
		st_d.sync2 = st_q.sync1;
		st_d.prev = st_q.sync2;
		val = st_q.sync2 ^ ch.invert;
		pval = st_q.prev ^ ch.invert;
		rise = val & ~pval;
		fall = ~val & pval;
		// Trigger has its own sense, independent of the interrupt sense
		st_d.trig = sense_hit(ch.trig_sense, ch.trig_level, val, rise, fall);
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign ch.result = val;
	assign ch.int_evt = sense_hit(ch.int_sense, ch.int_level, val, rise, fall);
	assign ch.trig = st_q.trig;
endmodule
`default_nettype wire

// ===== rtl/acc_top.sv
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module acc_top (
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic [7:0] I_ADDR,
	input wire logic [31:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [31:0] O_RDATA,
	input wire logic [acc_pkg::NUM_CHANNELS-1:0][acc_pkg::LEVEL_W-1:0] I_INVERTING_INPUT,
	input wire logic [acc_pkg::LEVEL_W-1:0] I_COMP_ZERO_PLUS_PIN,
	input wire logic [acc_pkg::LEVEL_W-1:0] I_COMP_ONE_SHARED_PIN,
	input wire logic [acc_pkg::LEVEL_W-1:0] I_COMP_TWO_PLUS_PIN,
	input wire logic [acc_pkg::LEVEL_W-1:0] I_AVDD_LEVEL,
	output logic O_COMP_ZERO_RESULT,
	output logic O_COMP_ONE_SHARED_PIN_O,
	output logic O_COMP_ONE_SHARED_PIN_OE,
	output logic [acc_pkg::NUM_CHANNELS-1:0] O_TRIGGER,
	output logic [acc_pkg::LEVEL_W-1:0] O_REF_LEVEL,
	output logic O_IRQ
);
	import acc_pkg::*;

	typedef struct packed {
		logic [NUM_CHANNELS-1:0] raw_irq;
		logic [NUM_CHANNELS-1:0] irq_mask;
		logic [REF_W-1:0] ladder;
		logic [NUM_CHANNELS-1:0][CTL_W-1:0] ctl;
		logic pin0;
		logic pin1;
		logic [31:0] rdata;
	} acc_top_s;

	acc_top_s st_q;
	acc_top_s st_d;

	logic [NUM_CHANNELS-1:0] result;
	logic [NUM_CHANNELS-1:0] int_evt;
	logic [NUM_CHANNELS-1:0] trig;
	logic [NUM_CHANNELS-1:0][LEVEL_W-1:0] own_plus;
	logic [NUM_CHANNELS-1:0][LEVEL_W-1:0] plus_level;
	logic [NUM_CHANNELS-1:0] raw_cmp;
	logic [LEVEL_W-1:0] ref_level;
	logic [14:0] ladder_prod;
	logic [14:0] ladder_quot;
	logic [3:0] tap;

	// ------------------------------------------------------------
	// Ladder reference
	// ------------------------------------------------------------
	always_comb begin
		tap = st_q.ladder[REF_TAP_LSB +: 4];
		ladder_prod = 15'h0000;
		ladder_quot = 15'h0000;
		if (!st_q.ladder[REF_EN_BIT]) begin
			ladder_quot = 15'h0000;
		end else if (st_q.ladder[REF_SPAN_BIT]) begin
			ladder_prod = 15'(I_AVDD_LEVEL) * 15'(tap);
			ladder_quot = ladder_prod / LADDER_TOTAL_HIGH_SPAN;
		end else begin
			ladder_prod = 15'(I_AVDD_LEVEL) * 15'({1'b0, tap} + LADDER_OFFSET_LOW_SPAN);
			ladder_quot = ladder_prod / LADDER_TOTAL_LOW_SPAN;
		end
		ref_level = ladder_quot[LEVEL_W-1:0];
	end

	// ------------------------------------------------------------
	// Input routing and comparison
	// ------------------------------------------------------------
	assign own_plus[0] = I_COMP_ZERO_PLUS_PIN;
	assign own_plus[1] = I_COMP_ONE_SHARED_PIN;
	assign own_plus[2] = I_COMP_TWO_PLUS_PIN;

	always_comb begin
		for (int c = 0; c < NUM_CHANNELS; c++) begin
			case (st_q.ctl[c][CTL_PLUS_SOURCE_LSB +: 2])
				SRC_OWN_PIN: plus_level[c] = own_plus[c];
				SRC_SHARED_PLUS: plus_level[c] = (c == 0) ? own_plus[0] : I_COMP_ZERO_PLUS_PIN;
				SRC_LADDER: plus_level[c] = ref_level;
				// Reserved code compares against ground so the result stays defined
				default: plus_level[c] = '0;
			endcase
			// Equal levels resolve to 0
			raw_cmp[c] = I_INVERTING_INPUT[c] < plus_level[c];
		end
	end

	// ------------------------------------------------------------
	// Channels
	// ------------------------------------------------------------
	acc_ch_if ch [NUM_CHANNELS] ();

	for (genvar g = 0; g < NUM_CHANNELS; g++) begin : g_chan
		assign ch[g].raw_cmp = raw_cmp[g];
		assign ch[g].invert = st_q.ctl[g][CTL_INVERT_BIT];
		assign ch[g].int_sense = st_q.ctl[g][CTL_INT_SENSE_LSB +: 2];
		assign ch[g].int_level = st_q.ctl[g][CTL_INT_LEVEL_BIT];
		assign ch[g].trig_sense = st_q.ctl[g][CTL_TRIG_SENSE_LSB +: 2];
		assign ch[g].trig_level = st_q.ctl[g][CTL_TRIG_LEVEL_BIT];
		assign result[g] = ch[g].result;
		assign int_evt[g] = ch[g].int_evt;
		assign trig[g] = ch[g].trig;

		acc_channel u_chan (
			.i_clk(I_CLK),
			.i_rst(I_RST),
			.ch(ch[g])
		);
	end

	// ------------------------------------------------------------
	// Register file and interrupt state
	// ------------------------------------------------------------
	always_comb begin
		logic [NUM_CHANNELS-1:0] clr;
		logic [7:0] rel;
		int idx;
		clr = '0;
		rel = 8'h00;
		idx = 0;
		st_d = st_q;

		if (I_WR) begin
			case (I_ADDR)
				OFF_MASKED_IRQ_STATUS: clr = I_WDATA[NUM_CHANNELS-1:0];
				OFF_IRQ_MASK_REG: st_d.irq_mask = I_WDATA[NUM_CHANNELS-1:0];
				OFF_LADDER_REFERENCE_CONTROL: st_d.ladder = I_WDATA[REF_W-1:0];
				default: begin
					if (I_ADDR >= OFF_CHANNEL_STATUS_BASE) begin
						rel = I_ADDR - OFF_CHANNEL_STATUS_BASE;
						idx = int'(rel[7:5]);
						if (idx < NUM_CHANNELS && rel[4:0] == 5'h04) begin
							st_d.ctl[idx] = I_WDATA[CTL_W-1:0];
						end
					end
				end
			endcase
		end

		// A condition in the same cycle as its clear keeps the bit set
		st_d.raw_irq = (st_q.raw_irq & ~clr) | int_evt;

		st_d.rdata = 32'h0000_0000;
		if (I_RD) begin
			case (I_ADDR)
				OFF_MASKED_IRQ_STATUS: st_d.rdata[NUM_CHANNELS-1:0] = st_q.raw_irq & st_q.irq_mask;
				OFF_RAW_IRQ_STATUS: st_d.rdata[NUM_CHANNELS-1:0] = st_q.raw_irq;
				OFF_IRQ_MASK_REG: st_d.rdata[NUM_CHANNELS-1:0] = st_q.irq_mask;
				OFF_LADDER_REFERENCE_CONTROL: st_d.rdata[REF_W-1:0] = st_q.ladder;
				default: begin
					if (I_ADDR >= OFF_CHANNEL_STATUS_BASE) begin
						rel = I_ADDR - OFF_CHANNEL_STATUS_BASE;
						idx = int'(rel[7:5]);
						if (idx < NUM_CHANNELS && rel[4:0] == 5'h00) begin
							st_d.rdata[STAT_RESULT_BIT] = result[idx];
						end else if (idx < NUM_CHANNELS && rel[4:0] == 5'h04) begin
							st_d.rdata[CTL_W-1:0] = st_q.ctl[idx];
						end
					end
				end
			endcase
		end

		st_d.pin0 = result[0];
		st_d.pin1 = result[1];
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			st_q.raw_irq <= IRQ_RESET;
			st_q.irq_mask <= IRQ_RESET;
			st_q.ladder <= REF_RESET;
			st_q.ctl <= {NUM_CHANNELS{CTL_RESET}};
			st_q.pin0 <= 1'b0;
			st_q.pin1 <= 1'b0;
			st_q.rdata <= 32'h0000_0000;
		end else begin
			st_q <= st_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign O_RDATA = st_q.rdata;
	assign O_COMP_ZERO_RESULT = st_q.pin0;
	// Channel 2 has no output pin; channel 1 drives only when enabled
	assign O_COMP_ONE_SHARED_PIN_O = st_q.pin1;
	assign O_COMP_ONE_SHARED_PIN_OE = st_q.ctl[1][CTL_PIN_ENABLE_BIT];
	assign O_TRIGGER = trig;
	assign O_REF_LEVEL = ref_level;
	assign O_IRQ = |(st_q.raw_irq & st_q.irq_mask);
endmodule
`default_nettype wire

// ===== verification/acc_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module acc_top_props (
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic [7:0] I_ADDR,
	input wire logic [31:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	input wire logic [31:0] O_RDATA,
	input wire logic [2:0][9:0] I_INVERTING_INPUT,
	input wire logic [9:0] I_COMP_ZERO_PLUS_PIN,
	input wire logic [9:0] I_AVDD_LEVEL,
	input wire logic O_COMP_ZERO_RESULT,
	input wire logic O_COMP_ONE_SHARED_PIN_OE,
	input wire logic [2:0] O_TRIGGER,
	input wire logic [9:0] O_REF_LEVEL,
	input wire logic O_IRQ
);
	logic [11:0] c0_q;
	logic [2:0] m_q;
	// ------------------------------------------------------------
	// Shadows of channel 0 control and the mask
	// ------------------------------------------------------------
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			c0_q <= 12'h000;
			m_q <= 3'h0;
		end else if (I_WR) begin
			if (I_ADDR == 8'h24) c0_q <= I_WDATA[11:0];
			if (I_ADDR == 8'h08) m_q <= I_WDATA[2:0];
		end
	end
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_RST);
	sequence s_rd(a);
		I_RD && I_ADDR == a;
	endsequence
	// Own pin, no invert, nothing moving for five edges: sync and pin flop have drained,
	// also for the attempt that starts on the edge that releases reset
	sequence s_in0_steady;
		(!c0_q[1] && !c0_q[10] && $stable(c0_q) && $stable(I_INVERTING_INPUT[0]) && $stable(I_COMP_ZERO_PLUS_PIN))[*5];
	endsequence
	property p_rdata_idle;
		!I_RD |=> O_RDATA == 32'h0;
	endproperty
	property p_mask_rd;
		s_rd(8'h08) |=> O_RDATA == {29'h0, $past(m_q)};
	endproperty
	property p_irq;
		s_rd(8'h00) |=> ((O_RDATA[2:0] != 3'h0) == $past(O_IRQ)) && ((O_RDATA[2:0] & ~$past(m_q)) == 3'h0);
	endproperty
	property p_ref_off;
		I_WR && I_ADDR == 8'h10 && !I_WDATA[9] |=> O_REF_LEVEL == 10'h000;
	endproperty
	property p_ref_lo;
		I_WR && I_ADDR == 8'h10 && I_WDATA[9:8] == 2'b10
			|=> O_REF_LEVEL == 10'((32'(I_AVDD_LEVEL) * (32'($past(I_WDATA[3:0])) + 8)) / 31);
	endproperty
	property p_ref_hi;
		I_WR && I_ADDR == 8'h10 && I_WDATA[9:8] == 2'b11
			|=> O_REF_LEVEL == 10'((32'(I_AVDD_LEVEL) * 32'($past(I_WDATA[3:0]))) / 23);
	endproperty
	property p_oe;
		I_WR && I_ADDR == 8'h44 |=> O_COMP_ONE_SHARED_PIN_OE == $past(I_WDATA[11]);
	endproperty
	property p_res0;
		s_in0_steady |-> O_COMP_ZERO_RESULT == (I_INVERTING_INPUT[0] < I_COMP_ZERO_PLUS_PIN);
	endproperty
	property p_trig;
		(c0_q[6] ^ c0_q[5]) && O_TRIGGER[0] |=> !O_TRIGGER[0];
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
	a_mask_rd: assert property (p_mask_rd) else $error("mask readback wrong");
	a_irq: assert property (p_irq) else $error("masked status and irq disagree");
	a_ref_off: assert property (p_ref_off) else $error("disabled ladder not ground");
	a_ref_lo: assert property (p_ref_lo) else $error("low span ladder level wrong");
	a_ref_hi: assert property (p_ref_hi) else $error("high span ladder level wrong");
	a_oe: assert property (p_oe) else $error("shared pin enable wrong");
	a_res0: assert property (p_res0) else $error("channel 0 result wrong");
	a_trig: assert property (p_trig) else $error("edge trigger longer than one cycle");
endmodule
bind acc_top acc_top_props u_props (.I_CLK(I_CLK), .I_RST(I_RST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
	.I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_INVERTING_INPUT(I_INVERTING_INPUT),
	.I_COMP_ZERO_PLUS_PIN(I_COMP_ZERO_PLUS_PIN), .I_AVDD_LEVEL(I_AVDD_LEVEL),
	.O_COMP_ZERO_RESULT(O_COMP_ZERO_RESULT), .O_COMP_ONE_SHARED_PIN_OE(O_COMP_ONE_SHARED_PIN_OE),
	.O_TRIGGER(O_TRIGGER), .O_REF_LEVEL(O_REF_LEVEL), .O_IRQ(O_IRQ));
`default_nettype wire

// ===== verification/acc_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
module acc_analog_model (
	input wire logic i_clk,
	output var logic [2:0][9:0] o_neg,
	output var logic [9:0] o_pos0,
	output var logic [9:0] o_pos1,
	output var logic [9:0] o_pos2,
	output var logic [9:0] o_avdd
);
	// Supply held still: the ladder checks use its present value
	initial begin
		o_neg = {10'd100, 10'd100, 10'd100};
		o_pos0 = 10'd500;
		o_pos1 = 10'd500;
		o_pos2 = 10'd50;
		o_avdd = 10'd460;
	end
	task automatic set_neg(input int ch, input logic [9:0] v);
		@(posedge i_clk);
		o_neg[ch] <= v;
	endtask
endmodule
`default_nettype wire

// ===== verification/acc_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module acc_top_tb_top;
	import acc_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic [NUM_CHANNELS-1:0][LEVEL_W-1:0] neg;
	logic [LEVEL_W-1:0] pos0, pos1, pos2, avdd, shared, ref_lvl;
	logic res0, pin1, oe1, irq;
	logic [2:0] trig;
	int miscompares = 0;
	int comparisons = 0;
	always #12.5 clk = ~clk;
	// Driven shared pin shows the channel's own rail level
	assign shared = oe1 ? (pin1 ? avdd : 10'h000) : pos1;
	acc_analog_model u_ana (.i_clk(clk), .o_neg(neg), .o_pos0(pos0), .o_pos1(pos1), .o_pos2(pos2), .o_avdd(avdd));
	acc_top u_dut (.I_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
		.O_RDATA(rdata), .I_INVERTING_INPUT(neg), .I_COMP_ZERO_PLUS_PIN(pos0), .I_COMP_ONE_SHARED_PIN(shared),
		.I_COMP_TWO_PLUS_PIN(pos2), .I_AVDD_LEVEL(avdd), .O_COMP_ZERO_RESULT(res0),
		.O_COMP_ONE_SHARED_PIN_O(pin1), .O_COMP_ONE_SHARED_PIN_OE(oe1), .O_TRIGGER(trig),
		.O_REF_LEVEL(ref_lvl), .O_IRQ(irq));
	// ------------------------------------------------------------
	// Bus and compare helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		// Let the write settle before any caller looks at outputs
		#1;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata & m, exp);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic count_trig(output int n);
		n = 0;
		repeat (8) begin
			@(posedge clk);
			#1 n += (trig[0] === 1'b0) ? 0 : 1;
		end
	endtask
	task automatic finish_test();
		$display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_regs();
		rd_chk(8'h24, 32'hffffffff, 32'h0);
		rd_chk(8'h10, 32'hffffffff, 32'h0);
		rd_chk(8'h08, 32'hffffffff, 32'h0);
		wr_reg(8'h08, 32'hffffffff);
		rd_chk(8'h08, 32'hffffffff, 32'h7);
		wr_reg(8'h08, 32'h0);
		rd_chk(8'h0c, 32'hffffffff, 32'h0);
		chk(irq, 0);
	endtask
	task automatic t_ladder();
		logic [9:0] v [4] = '{10'h30c, 10'h20c, 10'h10f, 10'h205};
		logic [31:0] e;
		foreach (v[i]) begin
			wr_reg(8'h10, {22'h0, v[i]});
			#1;
			e = !v[i][9] ? 0 : v[i][8] ? 32'(avdd) * v[i][3:0] / 23 : 32'(avdd) * (v[i][3:0] + 8) / 31;
			chk({22'h0, ref_lvl}, e);
			rd_chk(8'h10, 32'h3ff, {22'h0, v[i]});
		end
		wr_reg(8'h10, 32'h30c);
	endtask
	task automatic t_compare();
		wr_reg(8'h24, 32'h40c);
		idle(5);
		chk(res0, 1);
		rd_chk(8'h20, 32'h2, 32'h2);
		u_ana.set_neg(0, 10'd400);
		idle(5);
		chk(res0, 0);
		rd_chk(8'h04, 32'h1, 32'h1);
		chk(irq, 0);
		wr_reg(8'h00, 32'h0);
		rd_chk(8'h04, 32'h1, 32'h1);
		wr_reg(8'h08, 32'h1);
		chk(irq, 1);
		rd_chk(8'h00, 32'h7, 32'h1);
		wr_reg(8'h00, 32'h1);
		chk(irq, 0);
		rd_chk(8'h04, 32'h1, 32'h0);
	endtask
	task automatic t_trig();
		int n;
		wr_reg(8'h24, 32'h44c);
		u_ana.set_neg(0, 10'd100);
		count_trig(n);
		chk(n, 1);
		rd_chk(8'h04, 32'h1, 32'h1);
		wr_reg(8'h00, 32'h1);
		u_ana.set_neg(0, 10'd400);
		count_trig(n);
		chk(n, 0);
		rd_chk(8'h04, 32'h1, 32'h1);
	endtask
	task automatic t_source();
		wr_reg(8'h44, 32'ha00);
		u_ana.set_neg(1, 10'd600);
		idle(5);
		chk({oe1, pin1}, 2'b10);
		chk(trig[1], 1);
		u_ana.set_neg(1, 10'd100);
		idle(5);
		chk({oe1, pin1}, 2'b11);
		chk(trig[1], 0);
		for (int s = 0; s < 4; s++) begin
			wr_reg(8'h64, 32'(s) << 9);
			idle(4);
			rd_chk(8'h60, 32'h2, (s == 1 || s == 2) ? 32'h2 : 32'h0);
			chk(trig[2], (s == 1 || s == 2) ? 32'h0 : 32'h1);
		end
	endtask
	initial begin
		#100us;
		miscompares++;
		finish_test();
	end
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_ladder();
		t_compare();
		t_trig();
		t_source();
		finish_test();
	end
endmodule
`default_nettype wire
